// [core/dtc_timer_top.sv]
// two 16-bit timer/counters with overflow and irq edge flags, apb slave
// assumes count and irq pins synchronous to pclk; service acks one pulse
`timescale 1ns/1ps

module dtc_timer_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [4:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        first_count_input,
  input  wire logic        second_count_input,
  input  wire logic        ext_irq_a_pin,
  input  wire logic        ext_irq_b_pin,
  input  wire logic        first_timer_svc,
  input  wire logic        second_timer_svc,
  input  wire logic        ext_irq_a_svc,
  input  wire logic        ext_irq_b_svc,
  output logic             first_timer_irq,
  output logic             second_timer_irq,
  output logic             ext_irq_a_req,
  output logic             ext_irq_b_req
);

  // one step of a timer: {overflow, high, low}
  function automatic logic [16:0] dtc_step(
    input logic [1:0] mode,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    c13 = 14'({hi, lo[4:0]}) + 14'h0001;
    c16 = 17'({hi, lo}) + 17'h00001;
    c8  = 9'(lo) + 9'h001;
    case (mode)
      2'h0:    dtc_step = {c13[13], c13[12:5], 3'h0, c13[4:0]};
      2'h1:    dtc_step = c16;
      2'h2:    dtc_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
      default: dtc_step = {c8[8], hi, c8[7:0]};
    endcase
  endfunction

  logic [MC_CNT_W_L-1:0] mc_cnt_ff;
  localparam int unsigned MC_CNT_W_L = dtc_pkg::MC_CNT_W;
  logic        mc_tick_ff;
  logic [7:0]  tcf_ff;
  logic [7:0]  tms_ff;
  logic [7:0]  tl0_ff;
  logic [7:0]  th0_ff;
  logic [7:0]  tl1_ff;
  logic [7:0]  th1_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        irq_a_ff;
  logic        irq_b_ff;

  logic lvl_c0;
  logic fall_c0;
  logic lvl_c1;
  logic fall_c1;
  logic lvl_ia;
  logic fall_ia;
  logic lvl_ib;
  logic fall_ib;

  // machine cycle divider
  // one tick per 12 clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mc_cnt_ff  <= '0;
      mc_tick_ff <= 1'b0;
    end
    else
    begin
      mc_tick_ff <= (mc_cnt_ff == MC_CNT_W_L'(dtc_pkg::MC_CLOCKS - 1));
      if (mc_cnt_ff == MC_CNT_W_L'(dtc_pkg::MC_CLOCKS - 1))
        mc_cnt_ff <= '0;
      else
        mc_cnt_ff <= mc_cnt_ff + MC_CNT_W_L'(1);
    end
  end

  // pin sampling, once per machine cycle
  // fall needs two samples
  dtc_pin_sampler u_smp_c0 (
    .pclk    (pclk),
    .presetn (presetn),
    .mc_tick (mc_tick_ff),
    .pin     (first_count_input),
    .level   (lvl_c0),
    .fall    (fall_c0)
  );
  dtc_pin_sampler u_smp_c1 (
    .pclk    (pclk),
    .presetn (presetn),
    .mc_tick (mc_tick_ff),
    .pin     (second_count_input),
    .level   (lvl_c1),
    .fall    (fall_c1)
  );
  dtc_pin_sampler u_smp_ia (
    .pclk    (pclk),
    .presetn (presetn),
    .mc_tick (mc_tick_ff),
    .pin     (ext_irq_a_pin),
    .level   (lvl_ia),
    .fall    (fall_ia)
  );
  dtc_pin_sampler u_smp_ib (
    .pclk    (pclk),
    .presetn (presetn),
    .mc_tick (mc_tick_ff),
    .pin     (ext_irq_b_pin),
    .level   (lvl_ib),
    .fall    (fall_ib)
  );

  // apb decode; writes land on the access edge with pready
  wire       acc     = psel & penable & pready_ff;
  wire       wr      = acc & pwrite & pstrb[0];
  wire       mapped  = (paddr[1:0] == 2'h0) &&
                       (paddr <= dtc_pkg::OFS_STAT);
  wire       wr_tcf  = wr & (paddr == dtc_pkg::OFS_TCF);
  wire       wr_tms  = wr & (paddr == dtc_pkg::OFS_TMS);
  wire       wr_tl0  = wr & (paddr == dtc_pkg::OFS_TL0);
  wire       wr_th0  = wr & (paddr == dtc_pkg::OFS_TH0);
  wire       wr_tl1  = wr & (paddr == dtc_pkg::OFS_TL1);
  wire       wr_th1  = wr & (paddr == dtc_pkg::OFS_TH1);
  wire [7:0] wbyte   = pwdata[7:0];

  wire [1:0] mode0   = {tms_ff[dtc_pkg::B_M0HI], tms_ff[dtc_pkg::B_M0LO]};
  wire [1:0] mode1   = {tms_ff[dtc_pkg::B_M1HI], tms_ff[dtc_pkg::B_M1LO]};
  wire       split0  = (mode0 == 2'(dtc_pkg::MODE_SPLIT));
  wire       run0    = tcf_ff[dtc_pkg::B_TR0];
  wire       run1    = tcf_ff[dtc_pkg::B_TR1];

  // count sources
  // select bit picks source
  wire src0 = tms_ff[dtc_pkg::B_CT0] ? fall_c0 : mc_tick_ff;
  wire src1 = tms_ff[dtc_pkg::B_CT1] ? fall_c1 : mc_tick_ff;

  // enables
  // gate follows irq pin level
  wire en0 = run0 & (~tms_ff[dtc_pkg::B_GATE0] | lvl_ia);
  wire en1 = run1 & (~tms_ff[dtc_pkg::B_GATE1] | lvl_ib);

  // second timer halts in mode 11
  wire inc0 = src0 & en0;
  wire inc1 = src1 & en1 & (mode1 != 2'(dtc_pkg::MODE_SPLIT));
  // split high byte on second run
  wire inc0h = split0 & mc_tick_ff & run1;

  wire [16:0] stp0  = dtc_step(mode0, tl0_ff, th0_ff);
  wire [16:0] stp1  = dtc_step(mode1, tl1_ff, th1_ff);
  wire [8:0]  th0p1 = 9'(th0_ff) + 9'h001;

  wire set_tf0 = inc0 & stp0[16];
  wire set_tf1 = split0 ? (inc0h & th0p1[8]) : (inc1 & stp1[16]);
  // edge flags only in edge mode
  wire set_ie0 = tcf_ff[dtc_pkg::B_IT0] & fall_ia;
  wire set_ie1 = tcf_ff[dtc_pkg::B_IT1] & fall_ib;

  // flags: software write or service clears, set always wins
  wire keep_tf1 = wr_tcf ? wbyte[dtc_pkg::B_TF1] : tcf_ff[dtc_pkg::B_TF1];
  wire keep_tf0 = wr_tcf ? wbyte[dtc_pkg::B_TF0] : tcf_ff[dtc_pkg::B_TF0];
  wire keep_ie1 = wr_tcf ? wbyte[dtc_pkg::B_IE1] : tcf_ff[dtc_pkg::B_IE1];
  wire keep_ie0 = wr_tcf ? wbyte[dtc_pkg::B_IE0] : tcf_ff[dtc_pkg::B_IE0];

  wire nxt_tf1 = set_tf1 | (keep_tf1 & ~second_timer_svc);
  wire nxt_tf0 = set_tf0 | (keep_tf0 & ~first_timer_svc);
  wire nxt_ie1 = set_ie1 | (keep_ie1 & ~ext_irq_b_svc);
  wire nxt_ie0 = set_ie0 | (keep_ie0 & ~ext_irq_a_svc);

  wire nxt_tr1 = wr_tcf ? wbyte[dtc_pkg::B_TR1] : run1;
  wire nxt_tr0 = wr_tcf ? wbyte[dtc_pkg::B_TR0] : run0;
  wire nxt_it1 = wr_tcf ? wbyte[dtc_pkg::B_IT1] : tcf_ff[dtc_pkg::B_IT1];
  wire nxt_it0 = wr_tcf ? wbyte[dtc_pkg::B_IT0] : tcf_ff[dtc_pkg::B_IT0];

  wire [7:0] nxt_tcf = {nxt_tf1, nxt_tr1, nxt_tf0, nxt_tr0,
                        nxt_ie1, nxt_it1, nxt_ie0, nxt_it0};

  // counter bytes: a software write beats a same-cycle count
  wire [7:0] nxt_tl0 = wr_tl0 ? wbyte : (inc0 ? stp0[7:0] : tl0_ff);
  wire [7:0] nxt_th0 = wr_th0 ? wbyte :
                       (inc0h ? th0p1[7:0] :
                       ((inc0 & ~split0) ? stp0[15:8] : th0_ff));
  wire [7:0] nxt_tl1 = wr_tl1 ? wbyte : (inc1 ? stp1[7:0] : tl1_ff);
  wire [7:0] nxt_th1 = wr_th1 ? wbyte : (inc1 ? stp1[15:8] : th1_ff);

  wire nxt_irq_a = nxt_it0 ? nxt_ie0 : ~lvl_ia;
  wire nxt_irq_b = nxt_it1 ? nxt_ie1 : ~lvl_ib;

  // read mux; status shows sampled pin levels
  wire [7:0] stat = {4'h0, lvl_ib, lvl_ia, lvl_c1, lvl_c0};
  wire [7:0] rd_byte =
    (paddr == dtc_pkg::OFS_TCF)  ? tcf_ff :
    (paddr == dtc_pkg::OFS_TMS)  ? tms_ff :
    (paddr == dtc_pkg::OFS_TL0)  ? tl0_ff :
    (paddr == dtc_pkg::OFS_TH0)  ? th0_ff :
    (paddr == dtc_pkg::OFS_TL1)  ? tl1_ff :
    (paddr == dtc_pkg::OFS_TH1)  ? th1_ff :
    (paddr == dtc_pkg::OFS_STAT) ? stat   : 8'h00;
  wire setup = psel & ~penable;

  // apb answer: one wait-free access cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup)
        prdata_ff <= {24'h000000, rd_byte};
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tcf_ff <= dtc_pkg::RST_TCF;
      tms_ff <= dtc_pkg::RST_TMS;
    end
    else
    begin
      tcf_ff <= nxt_tcf;
      if (wr_tms)
        tms_ff <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tl0_ff <= dtc_pkg::RST_BYTE;
      th0_ff <= dtc_pkg::RST_BYTE;
      tl1_ff <= dtc_pkg::RST_BYTE;
      th1_ff <= dtc_pkg::RST_BYTE;
    end
    else
    begin
      tl0_ff <= nxt_tl0;
      th0_ff <= nxt_th0;
      tl1_ff <= nxt_tl1;
      th1_ff <= nxt_th1;
    end
  end

  // request outputs registered alongside their flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_a_ff <= 1'b0;
      irq_b_ff <= 1'b0;
    end
    else
    begin
      irq_a_ff <= nxt_irq_a;
      irq_b_ff <= nxt_irq_b;
    end
  end

  // outputs straight from flops
  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign first_timer_irq  = tcf_ff[dtc_pkg::B_TF0];
  assign second_timer_irq = tcf_ff[dtc_pkg::B_TF1];
  assign ext_irq_a_req    = irq_a_ff;
  assign ext_irq_b_req    = irq_b_ff;

endmodule // dtc_timer_top

// [core/dtc_pkg.sv]
// constants, field positions and types for the dual timer/counter block
// assumes one 100 MHz core clock and an APB master with 32-bit data

package dtc_pkg;

  // machine cycle length in core clocks
  localparam int unsigned MC_CLOCKS = 12;
  localparam int unsigned MC_CNT_W  = 4;

  // apb word offsets (byte addresses)
  localparam logic [4:0] OFS_TCF  = 5'h00;
  localparam logic [4:0] OFS_TMS  = 5'h04;
  localparam logic [4:0] OFS_TL0  = 5'h08;
  localparam logic [4:0] OFS_TH0  = 5'h0C;
  localparam logic [4:0] OFS_TL1  = 5'h10;
  localparam logic [4:0] OFS_TH1  = 5'h14;
  localparam logic [4:0] OFS_STAT = 5'h18;

  // timer_control_flags bit positions
  localparam int unsigned B_TF1 = 7;
  localparam int unsigned B_TR1 = 6;
  localparam int unsigned B_TF0 = 5;
  localparam int unsigned B_TR0 = 4;
  localparam int unsigned B_IE1 = 3;
  localparam int unsigned B_IT1 = 2;
  localparam int unsigned B_IE0 = 1;
  localparam int unsigned B_IT0 = 0;

  // timer_mode_select bit positions
  localparam int unsigned B_GATE1 = 7;
  localparam int unsigned B_CT1   = 6;
  localparam int unsigned B_M1HI  = 5;
  localparam int unsigned B_M1LO  = 4;
  localparam int unsigned B_GATE0 = 3;
  localparam int unsigned B_CT0   = 2;
  localparam int unsigned B_M0HI  = 1;
  localparam int unsigned B_M0LO  = 0;

  // reset values
  localparam logic [7:0] RST_TCF  = 8'h00;
  localparam logic [7:0] RST_TMS  = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // per-timer operating modes
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'h0,
    MODE_16BIT  = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT  = 2'h3
  } dtc_mode_type;

endpackage

// [core/dtc_pin_sampler.sv]
// samples one pin once per machine cycle and flags a falling edge
// assumes the pin is synchronous to pclk and tick is a one-cycle pulse
`timescale 1ns/1ps

module dtc_pin_sampler (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic mc_tick,
  input  wire logic pin,
  output logic      level,
  output logic      fall
);

  logic level_ff;
  logic fall_ff;

  // idle level is high so reset fakes no edge unless the pin is low out of reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_ff <= 1'b1;
      fall_ff  <= 1'b0;
    end
    else
    begin
      fall_ff <= mc_tick & level_ff & ~pin;
      if (mc_tick)
        level_ff <= pin;
    end
  end

  assign level = level_ff;
  assign fall  = fall_ff;

endmodule // dtc_pin_sampler

// [test/dtc_pin_model.sv]
// pin source for a count input or irq pin of the timer block
// assumes one bench process calls its tasks at a time
`timescale 1ns/1ps

module dtc_pin_model (
  input  wire logic pclk,
  output logic      pin
);
  // idles high like a pulled-up pin
  initial pin = 1'b1;

  task automatic pulse(input int n);
    repeat (n)
    begin
      repeat (24) @(posedge pclk);
      pin <= 1'b0;
      repeat (24) @(posedge pclk);
      pin <= 1'b1;
    end
    repeat (24) @(posedge pclk);
  endtask

  // level change right after an edge
  task automatic set_level(input logic v);
    @(posedge pclk);
    pin <= v;
  endtask
endmodule // dtc_pin_model

// [test/dtc_timer_top_chk.sv]
// checker on the apb side and flag outputs of the timer block
// assumes it is bound to dtc_timer_top and sees only its ports
`timescale 1ns/1ps

module dtc_timer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [4:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        first_timer_svc,
  input wire logic        second_timer_svc,
  input wire logic        first_timer_irq,
  input wire logic        second_timer_irq,
  input wire logic        ext_irq_a_req
);
  // flags may fall only by service or a software write
  wire setup_cyc = psel && !penable;
  wire unmapped  = paddr > 5'h18 || paddr[1:0] != 2'h0;
  wire tcf_wr    = psel && penable && pwrite && pready && paddr == 5'h00;
  wire clr_a     = first_timer_svc || tcf_wr;
  wire clr_b     = second_timer_svc || tcf_wr;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PREADY_SETUP: assert property (setup_cyc |=> pready)
    else $error("pready missing after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_CAUSE: assert property (pready |-> $past(setup_cyc))
    else $error("pready without setup");
  AST_ERR_UNMAP: assert property (setup_cyc && unmapped |=> pslverr)
    else $error("no error on unmapped address");
  AST_ERR_MAPPED: assert property (setup_cyc && !unmapped |=> !pslverr)
    else $error("error on mapped address");
  AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_TF0_CLEAR: assert property ($fell(first_timer_irq) |->
    $past(clr_a) || $past(clr_a, 2))
    else $error("first overflow flag fell unasked");
  AST_TF1_CLEAR: assert property ($fell(second_timer_irq) |->
    $past(clr_b) || $past(clr_b, 2))
    else $error("second overflow flag fell unasked");

  // main scenarios reached
  cover property ($rose(first_timer_irq));
  cover property ($rose(second_timer_irq));
  cover property (setup_cyc && unmapped);
  cover property ($rose(ext_irq_a_req));
endmodule // dtc_timer_chk

bind dtc_timer_top dtc_timer_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .first_timer_svc(first_timer_svc),
  .second_timer_svc(second_timer_svc), .first_timer_irq(first_timer_irq),
  .second_timer_irq(second_timer_irq), .ext_irq_a_req(ext_irq_a_req)
);

// [test/test_dual_timer_counter.sv]
// self-checking bench for the dual timer/counter block
// assumes pin models drive count input a and irq pin a
`timescale 1ns/1ps

module test_dual_timer_counter;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [4:0]  paddr = 5'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cnt_a;
  logic        pin_a;
  logic [3:0]  svc = 4'h0;
  logic [3:0]  irq;
  logic [7:0]  a, b, c, d, f, g;
  logic        e;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;

  always #5 pclk = ~pclk;

  dtc_timer_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_count_input(cnt_a), .second_count_input(1'b1),
    .ext_irq_a_pin(pin_a), .ext_irq_b_pin(1'b1),
    .first_timer_svc(svc[0]), .second_timer_svc(svc[1]),
    .ext_irq_a_svc(svc[2]), .ext_irq_b_svc(svc[3]),
    .first_timer_irq(irq[0]), .second_timer_irq(irq[1]),
    .ext_irq_a_req(irq[2]), .ext_irq_b_req(irq[3])
  );
  dtc_pin_model u_cnt (.pclk(pclk), .pin(cnt_a));
  dtc_pin_model u_pin (.pclk(pclk), .pin(pin_a));

  task automatic give_verdict;
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] v);
    compares++;
    if (v !== x)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, x, v);
    end
  endtask

  // one apb transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [4:0] ad,
                     input logic [7:0] dt, output logic [7:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, dt};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [4:0] ad, input logic [7:0] dt);
    apb(1'b1, ad, dt, d);
  endtask

  task automatic rd(input logic [4:0] ad, output logic [7:0] q);
    apb(1'b0, ad, 8'h00, q);
  endtask

  task automatic wait_irq(input int i);
    for (int k = 0; k < 100 && irq[i] !== 1'b1; k++)
      @(posedge pclk);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 6; i++)
    begin
      rd(5'(4 * i), a);
      chk("reset value", 8'h00, a);
    end
    rd(5'h1C, a);
    chk("unmapped error", 8'h01, {7'h0, e});
  endtask

  task automatic t_timer;
    wr(dtc_pkg::OFS_TMS, 8'h01);
    wr(dtc_pkg::OFS_TCF, 8'h10);
    rd(dtc_pkg::OFS_TL0, a);
    repeat (117) @(posedge pclk);
    rd(dtc_pkg::OFS_TL0, b);
    chk("timer rate", 8'd10, 8'(b - a));
    wr(dtc_pkg::OFS_TCF, 8'h00);
    rd(dtc_pkg::OFS_TL0, a);
    repeat (117) @(posedge pclk);
    rd(dtc_pkg::OFS_TL0, b);
    chk("stopped hold", a, b);
  endtask

  task automatic t_ovf;
    for (int i = 0; i < 2; i++)
    begin
      wr(dtc_pkg::OFS_TMS, 8'h11);
      wr(5'(dtc_pkg::OFS_TH0 + 8 * i), 8'hFF);
      wr(5'(dtc_pkg::OFS_TL0 + 8 * i), 8'hFE);
      wr(dtc_pkg::OFS_TCF, i ? 8'h40 : 8'h10);
      wait_irq(i);
      rd(dtc_pkg::OFS_TCF, a);
      chk("ovf flag", 8'h01, {7'h0, a[5 + 2 * i]});
      rd(5'(dtc_pkg::OFS_TH0 + 8 * i), a);
      chk("carry wrap", 8'h00, a);
      svc[i] <= 1'b1;
      @(posedge pclk);
      svc[i] <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("svc clear", 8'h00, {7'h0, irq[i]});
      wr(dtc_pkg::OFS_TCF, 8'h00);
    end
  endtask

  task automatic t_mode0;
    wr(dtc_pkg::OFS_TMS, 8'h00);
    wr(dtc_pkg::OFS_TH0, 8'hFF);
    wr(dtc_pkg::OFS_TL0, 8'h1E);
    wr(dtc_pkg::OFS_TCF, 8'h10);
    wait_irq(0);
    wr(dtc_pkg::OFS_TCF, 8'h00);
    chk("13 bit flag", 8'h01, {7'h0, d[5]});
    rd(dtc_pkg::OFS_TH0, a);
    chk("13 bit wrap", 8'h00, a);
    rd(dtc_pkg::OFS_TL0, a);
    chk("low top zero", 8'h00, {5'h0, a[7:5]});
  endtask

  task automatic t_reload;
    wr(dtc_pkg::OFS_TMS, 8'h22);
    wr(dtc_pkg::OFS_TH0, 8'hF0);
    wr(dtc_pkg::OFS_TL0, 8'hFE);
    wr(dtc_pkg::OFS_TCF, 8'h10);
    wait_irq(0);
    rd(dtc_pkg::OFS_TL0, a);
    chk("reload low", 8'h0F, {4'h0, a[7:4]});
    rd(dtc_pkg::OFS_TH0, a);
    chk("reload keep", 8'hF0, a);
    wr(dtc_pkg::OFS_TCF, 8'h00);
  endtask

  task automatic t_count;
    wr(dtc_pkg::OFS_TMS, 8'h05);
    wr(dtc_pkg::OFS_TCF, 8'h10);
    rd(dtc_pkg::OFS_TL0, a);
    u_cnt.pulse(5);
    rd(dtc_pkg::OFS_TL0, b);
    chk("edge count", 8'd5, 8'(b - a));
    wr(dtc_pkg::OFS_TCF, 8'h00);
  endtask

  task automatic t_gate;
    wr(dtc_pkg::OFS_TMS, 8'h09);
    wr(dtc_pkg::OFS_TCF, 8'h10);
    u_pin.set_level(1'b0);
    repeat (30) @(posedge pclk);
    chk("level req", 8'h01, {7'h0, irq[2]});
    rd(dtc_pkg::OFS_TL0, a);
    repeat (117) @(posedge pclk);
    rd(dtc_pkg::OFS_TL0, b);
    chk("gate closed", a, b);
    u_pin.set_level(1'b1);
    repeat (30) @(posedge pclk);
    chk("level idle", 8'h00, {7'h0, irq[2]});
    rd(dtc_pkg::OFS_TL0, a);
    repeat (117) @(posedge pclk);
    rd(dtc_pkg::OFS_TL0, b);
    chk("gate open", 8'd10, 8'(b - a));
    wr(dtc_pkg::OFS_TCF, 8'h00);
  endtask

  task automatic t_edge;
    wr(dtc_pkg::OFS_TCF, 8'h01);
    u_pin.set_level(1'b0);
    repeat (30) @(posedge pclk);
    rd(dtc_pkg::OFS_TCF, a);
    chk("edge flag", 8'h01, {7'h0, a[1]});
    u_pin.set_level(1'b1);
    repeat (30) @(posedge pclk);
    chk("edge latched", 8'h01, {7'h0, irq[2]});
    svc[2] <= 1'b1;
    @(posedge pclk);
    svc[2] <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("edge svc", 8'h00, {7'h0, irq[2]});
  endtask

  task automatic t_split;
    wr(dtc_pkg::OFS_TMS, 8'h33);
    wr(dtc_pkg::OFS_TCF, 8'h40);
    rd(dtc_pkg::OFS_TL0, a);
    rd(dtc_pkg::OFS_TH0, c);
    rd(dtc_pkg::OFS_TL1, f);
    repeat (111) @(posedge pclk);
    rd(dtc_pkg::OFS_TL0, b);
    chk("split low idle", a, b);
    rd(dtc_pkg::OFS_TH0, d);
    chk("split high", 8'd10, 8'(d - c));
    rd(dtc_pkg::OFS_TL1, g);
    chk("mode 3 hold", f, g);
  endtask

  // hang guard, far above the expected run
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      give_verdict;
    end
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_timer;
    t_ovf;
    t_mode0;
    t_reload;
    t_count;
    t_gate;
    t_edge;
    t_split;
    give_verdict;
  end
endmodule // test_dual_timer_counter
